// >>> src/ctbc_pkg.sv
// Purpose: shared constants and types for the proximity card state logic
// Assumes: decoded commands arrive as one-cycle strobes from a frame decoder
// Notes:   frame size table maps the reader frame size index to bytes
package ctbc_pkg;

    // command codes from the frame decoder
    localparam logic [2:0] CTBC_CMD_REQUEST  = 3'h0;
    localparam logic [2:0] CTBC_CMD_WAKEUP   = 3'h1;
    localparam logic [2:0] CTBC_CMD_SLOT     = 3'h2;
    localparam logic [2:0] CTBC_CMD_HALT     = 3'h3;
    localparam logic [2:0] CTBC_CMD_ACTIVATE = 3'h4;
    localparam logic [2:0] CTBC_CMD_IBLOCK   = 3'h5;
    localparam logic [2:0] CTBC_CMD_RELEASE  = 3'h6;

    // answer codes towards the frame encoder
    localparam logic [2:0] CTBC_ANS_REQUEST  = 3'h1;
    localparam logic [2:0] CTBC_ANS_ACTIVATE = 3'h2;
    localparam logic [2:0] CTBC_ANS_HALT     = 3'h3;
    localparam logic [2:0] CTBC_ANS_RELEASE  = 3'h4;
    localparam logic [2:0] CTBC_ANS_BLOCK    = 3'h5;

    // field widths, limits and reset values
    localparam int         CTBC_ID_W         = 32;
    localparam int         CTBC_FAM_W        = 8;
    localparam logic [3:0] CTBC_FSDI_MAX     = 4'h8;
    localparam logic [8:0] CTBC_FSD_RESET    = 9'h010;
    localparam logic [3:0] CTBC_LFSR_SEED    = 4'h1;

    // frame waiting time and its budget in 10 ns cycles (rounded down)
    localparam int         CTBC_FWT_NS       = 4833;
    localparam int         CTBC_CLK_NS       = 10;
    localparam int         CTBC_FWT_CYC      = CTBC_FWT_NS / CTBC_CLK_NS;
    localparam logic [9:0] CTBC_FWT_CYC_V    = 10'(CTBC_FWT_CYC);

    // card states, one-hot
    typedef enum logic [4:0] {
        CTBC_IDLE     = 5'h01,
        CTBC_PENDING  = 5'h02,
        CTBC_ANSWERED = 5'h04,
        CTBC_ACTIVE   = 5'h08,
        CTBC_HALTED   = 5'h10
    } ctbc_state_t;

    typedef struct packed {
        ctbc_state_t st;
        logic [3:0]  lfsr;
        logic [4:0]  slot;
        logic [8:0]  reader_frame_size;
        logic        wait_rsp;
        logic [9:0]  fwt_cnt;
        logic        ans_vld;
        logic [2:0]  ans_code;
        logic [8:0]  ans_len;
        logic        fwt_err;
    } ctbc_regs_t;

endpackage

// >>> src/ctbc_card.sv
// Purpose: card-side command interpreter, from field power-up to exchange
// Assumes: commands decoded upstream; crc_ok and id/family match flags valid with cmd_vld_i
// Notes:   multi-slot support is built in; slot drawn from a 4-bit de Bruijn lfsr
`timescale 1ns/1ps
`default_nettype none
module ctbc_card
    import ctbc_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        en_i,
    // decoded command
    input  wire logic        cmd_vld_i,
    input  wire logic [2:0]  cmd_code_i,
    input  wire logic        crc_ok_i,
    input  wire logic        fam_match_i,
    input  wire logic        id_match_i,
    input  wire logic [2:0]  slot_exp_i,
    input  wire logic [4:0]  slot_num_i,
    input  wire logic [3:0]  fsdi_i,
    // response data from application
    input  wire logic        rsp_rdy_i,
    input  wire logic [8:0]  rsp_len_i,
    // answer towards encoder, plus state, frame size and waiting time error
    output logic             ans_vld_o,
    output logic [2:0]       ans_code_o,
    output logic [8:0]       ans_len_o,
    output logic [4:0]       state_o,
    output logic [8:0]       fsd_o,
    output logic             fwt_err_o
);

    ctbc_regs_t q;
    ctbc_regs_t d;

    // frame size index to bytes
    function automatic logic [8:0] fsd_of(input logic [3:0] idx);
        unique case (idx)
            4'h0:    fsd_of = 9'd16;
            4'h1:    fsd_of = 9'd24;
            4'h2:    fsd_of = 9'd32;
            4'h3:    fsd_of = 9'd40;
            4'h4:    fsd_of = 9'd48;
            4'h5:    fsd_of = 9'd64;
            4'h6:    fsd_of = 9'd96;
            4'h7:    fsd_of = 9'd128;
            default: fsd_of = 9'd256;
        endcase
    endfunction

    // slot drawn from lfsr, masked to slot count 2^e; 1-based; codes above 4 act as sixteen
    function automatic logic [4:0] draw_slot(input logic [3:0] r, input logic [2:0] e);
        logic [3:0] m;
        m = 4'h0;
        unique case (e)
            3'h1:    m = 4'h1;
            3'h2:    m = 4'h3;
            3'h3:    m = 4'h7;
            default: m = 4'hf;
        endcase
        draw_slot = {1'b0, r & m} + 5'h01;
    endfunction

    logic       is_init;
    logic       good;
    logic       multi;
    logic [4:0] drawn;

    // command class and draw
    always_comb
    begin
        good    = cmd_vld_i && crc_ok_i;
        is_init = cmd_code_i inside {CTBC_CMD_REQUEST, CTBC_CMD_WAKEUP, CTBC_CMD_SLOT,
                                     CTBC_CMD_HALT, CTBC_CMD_ACTIVATE};
        multi   = (slot_exp_i != 3'h0);
        drawn   = draw_slot(q.lfsr, slot_exp_i);
    end

    // next state
    always_comb
    begin
        d         = q;
        d.ans_vld = 1'b0;
        d.fwt_err = 1'b0;
        // uniform slot source
        // de Bruijn step: period 16, zero included, so every masked slot is equally likely
        d.lfsr    = {q.lfsr[2:0], q.lfsr[3] ^ q.lfsr[2] ^ (q.lfsr[2:0] == 3'h0)};
        if (q.wait_rsp)
        begin
            d.fwt_cnt = q.fwt_cnt + 10'h001;
            if (rsp_rdy_i)
            begin
                d.wait_rsp = 1'b0;
                d.ans_vld  = 1'b1;
                d.ans_code = CTBC_ANS_BLOCK;
                d.ans_len  = (rsp_len_i > q.reader_frame_size) ? q.reader_frame_size : rsp_len_i;
            end
            else if (q.fwt_cnt >= CTBC_FWT_CYC_V - 10'h001)
            begin
                d.wait_rsp = 1'b0;
                d.fwt_err  = 1'b1;
            end
        end
        if (good)
        begin
            unique case (q.st)
                CTBC_IDLE, CTBC_PENDING, CTBC_ANSWERED, CTBC_HALTED:
                begin
                    // halted: request, probe, halt, activate ignored
                    if ((cmd_code_i == CTBC_CMD_WAKEUP) ||
                        (cmd_code_i == CTBC_CMD_REQUEST && q.st != CTBC_HALTED))
                    begin
                        if (!fam_match_i)
                        begin
                            if (cmd_code_i == CTBC_CMD_WAKEUP || q.st != CTBC_HALTED)
                                d.st = CTBC_IDLE;
                        end
                        else if (multi && drawn != 5'h01)
                        begin
                            d.st   = CTBC_PENDING;
                            d.slot = drawn;
                        end
                        else
                        begin
                            d.st       = CTBC_ANSWERED;
                            d.ans_vld  = 1'b1;
                            d.ans_code = CTBC_ANS_REQUEST;
                            d.ans_len  = 9'h000;
                        end
                    end
                    else if (cmd_code_i == CTBC_CMD_SLOT && q.st == CTBC_PENDING &&
                             slot_num_i == q.slot)
                    begin
                        d.st       = CTBC_ANSWERED;
                        d.ans_vld  = 1'b1;
                        d.ans_code = CTBC_ANS_REQUEST;
                        d.ans_len  = 9'h000;
                    end
                    else if (cmd_code_i == CTBC_CMD_HALT && q.st == CTBC_ANSWERED && id_match_i)
                    begin
                        d.st       = CTBC_HALTED;
                        d.ans_vld  = 1'b1;
                        d.ans_code = CTBC_ANS_HALT;
                        d.ans_len  = 9'h000;
                    end
                    // matching activate with size index 0..8
                    else if (cmd_code_i == CTBC_CMD_ACTIVATE && q.st == CTBC_ANSWERED &&
                             id_match_i && fsdi_i <= CTBC_FSDI_MAX)
                    begin
                        d.st       = CTBC_ACTIVE;
                        d.reader_frame_size      = fsd_of(fsdi_i);
                        d.ans_vld  = 1'b1;
                        d.ans_code = CTBC_ANS_ACTIVATE;
                        d.ans_len  = 9'h000;
                    end
                end
                CTBC_ACTIVE:
                begin
                    if (cmd_code_i == CTBC_CMD_IBLOCK && !q.wait_rsp)
                    begin
                        d.wait_rsp = 1'b1;
                        d.fwt_cnt  = 10'h000;
                    end
                    else if (cmd_code_i == CTBC_CMD_RELEASE)
                    begin
                        d.st       = CTBC_HALTED;
                        d.wait_rsp = 1'b0;
                        d.ans_vld  = 1'b1;
                        d.ans_code = CTBC_ANS_RELEASE;
                        d.ans_len  = 9'h000;
                    end
                end
            endcase
        end
        // bad frame check: no command branch above fired, state kept; a pending response still completes
    end

    // state register; reset lands in idle, silent
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            q          <= '0;
            q.st       <= CTBC_IDLE;
            q.lfsr     <= CTBC_LFSR_SEED;
            q.reader_frame_size      <= CTBC_FSD_RESET;
            q.ans_code <= 3'h0;
        end
        else if (en_i)
        begin
            q <= d;
        end
    end

    assign ans_vld_o  = q.ans_vld;
    assign ans_code_o = q.ans_code;
    assign ans_len_o  = q.ans_len;
    assign state_o    = q.st;
    assign fsd_o      = q.reader_frame_size;
    assign fwt_err_o  = q.fwt_err;

    // assertions
    property p_halt_silent;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && q.st == CTBC_HALTED && cmd_vld_i && cmd_code_i != CTBC_CMD_WAKEUP)
            |=> (!ans_vld_o && state_o == CTBC_HALTED);
    endproperty
    a_halt_silent: assert property (p_halt_silent) else $error("halted card answered");

    property p_active_mute;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && q.st == CTBC_ACTIVE && cmd_vld_i && is_init)
            |=> (state_o == CTBC_ACTIVE && (!ans_vld_o || ans_code_o == CTBC_ANS_BLOCK));
    endproperty
    a_active_mute: assert property (p_active_mute) else $error("active card left state");

    property p_release;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && good && q.st == CTBC_ACTIVE && cmd_code_i == CTBC_CMD_RELEASE)
            |=> (ans_vld_o && ans_code_o == CTBC_ANS_RELEASE && state_o == CTBC_HALTED);
    endproperty
    a_release: assert property (p_release) else $error("release not echoed");

    property p_len_limit;
        @(posedge clk_i) disable iff (!nrst_i)
        (ans_vld_o && ans_code_o == CTBC_ANS_BLOCK) |-> (ans_len_o <= fsd_o);
    endproperty
    a_len_limit: assert property (p_len_limit) else $error("block exceeds frame size");

    property p_bad_crc;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && cmd_vld_i && !crc_ok_i && !q.wait_rsp) |=> (!ans_vld_o && $stable(state_o));
    endproperty
    a_bad_crc: assert property (p_bad_crc) else $error("damaged frame acted on");

    property p_wrong_id;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && good && q.st == CTBC_ANSWERED && cmd_code_i == CTBC_CMD_ACTIVATE && !id_match_i)
            |=> (state_o == CTBC_ANSWERED && !ans_vld_o);
    endproperty
    a_wrong_id: assert property (p_wrong_id) else $error("foreign activate accepted");

    property p_fsdi;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && good && q.st == CTBC_ANSWERED && cmd_code_i == CTBC_CMD_ACTIVATE && id_match_i
            && fsdi_i <= CTBC_FSDI_MAX)
            |=> (ans_code_o == CTBC_ANS_ACTIVATE && fsd_o == fsd_of($past(fsdi_i)));
    endproperty
    a_fsdi: assert property (p_fsdi) else $error("frame size not stored");

    property p_slot_range;
        @(posedge clk_i) disable iff (!nrst_i)
        (q.st == CTBC_PENDING) |-> (q.slot >= 5'h02 && q.slot <= 5'h10);
    endproperty
    a_slot_range: assert property (p_slot_range) else $error("pending slot out of range");

    property p_probe_other;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && good && q.st == CTBC_PENDING && cmd_code_i == CTBC_CMD_SLOT && slot_num_i != q.slot)
            |=> (!ans_vld_o && state_o == CTBC_PENDING);
    endproperty
    a_probe_other: assert property (p_probe_other) else $error("probe for another slot answered");

    property p_wake_halted;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && good && q.st == CTBC_HALTED && cmd_code_i == CTBC_CMD_WAKEUP && fam_match_i && !multi)
            |=> (ans_vld_o && ans_code_o == CTBC_ANS_REQUEST && state_o == CTBC_ANSWERED);
    endproperty
    a_wake_halted: assert property (p_wake_halted) else $error("halted card ignored wakeup");

    property p_fwt;
        @(posedge clk_i) disable iff (!nrst_i)
        q.wait_rsp |-> (q.fwt_cnt < CTBC_FWT_CYC_V);
    endproperty
    a_fwt: assert property (p_fwt) else $error("frame waiting time overrun");

endmodule
`default_nettype wire

// >>> sim/ctbc_reader.sv
// Purpose: reader model driving decoded commands into the card
// Assumes: card answers in the cycle after the strobe
// Notes:   idle fields carry the inverse of the last command
`timescale 1ns/1ps
`default_nettype none
module ctbc_reader
    import ctbc_pkg::*;
(
    // clock and card answer
    input  wire logic        clk_i,
    input  wire logic        ans_vld_i,
    input  wire logic [2:0]  ans_code_i,
    // packed command fields towards the card
    output logic             cmd_vld_o,
    output logic [17:0]      cmd_o
);
    // quiet at time zero
    initial
    begin
        cmd_vld_o = 1'b0;
        cmd_o = 18'h0;
    end

    // strobe one command, take the answer in the cycle after the strobe
    task automatic send(input logic [17:0] c, output logic [2:0] got);
        @(negedge clk_i);
        cmd_vld_o = 1'b1;
        cmd_o = c;
        @(negedge clk_i);
        cmd_vld_o = 1'b0;
        cmd_o = ~c; // stale fields must not look valid
        got = (ans_vld_i === 1'b1) ? ans_code_i : 3'h0;
        @(negedge clk_i);
        // an answer here is late or doubled; code 7 is never sent, so any compare fails
        if (ans_vld_i === 1'b1)
            got = 3'h7;
    endtask

    task automatic round(input logic [2:0] e, output int hits, output int slot);
        logic [2:0] g;
        hits = 0;
        slot = 0;
        for (int j = 1; j <= (1 << e); j++)
        begin
            send((j == 1) ? {CTBC_CMD_REQUEST, 3'h7, e, 9'h0} : {CTBC_CMD_SLOT, 3'h7, 3'h0, 5'(j), 4'h0}, g);
            if (g === CTBC_ANS_REQUEST)
            begin
                hits++;
                slot = j;
            end
        end
    endtask
endmodule
`default_nettype wire

// >>> sim/contactless_typeb_card_state_logic_tb.sv
// Purpose: self-checking bench for the card state logic
// Assumes: one command at a time through the reader model
// Notes:   slot draws are random, so rounds are judged by count
`timescale 1ns/1ps
`default_nettype none
module contactless_typeb_card_state_logic_tb
    import ctbc_pkg::*;
();
    logic        clk_i;
    logic        nrst_i;
    logic        en_i;
    logic        rsp_rdy_i;
    logic [8:0]  rsp_len_i;
    logic        cmd_vld;
    logic [17:0] cmd;
    logic        ans_vld;
    logic [2:0]  ans_code;
    logic [8:0]  ans_len;
    logic [4:0]  state;
    logic [8:0]  reader_frame_size;
    logic        fwt_err;
    logic [4:0]  m_st;
    logic [8:0]  m_fsd;
    logic [31:0] lfsr_q;
    logic [16:0] seen;
    logic [2:0]  g;
    int          n_fail;
    int          n_tests;
    int          cyc = 0;
    int          n;
    int          hits;
    int          slot;
    int          fsd_tbl [9] = '{16, 24, 32, 40, 48, 64, 96, 128, 256};

    ctbc_card uut (
        .clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i), .cmd_vld_i(cmd_vld), .cmd_code_i(cmd[17:15]),
        .crc_ok_i(cmd[14]), .fam_match_i(cmd[13]), .id_match_i(cmd[12]), .slot_exp_i(cmd[11:9]),
        .slot_num_i(cmd[8:4]), .fsdi_i(cmd[3:0]), .rsp_rdy_i(rsp_rdy_i), .rsp_len_i(rsp_len_i),
        .ans_vld_o(ans_vld), .ans_code_o(ans_code), .ans_len_o(ans_len), .state_o(state),
        .fsd_o(reader_frame_size), .fwt_err_o(fwt_err)
    );
    ctbc_reader rdr (
        .clk_i(clk_i), .ans_vld_i(ans_vld), .ans_code_i(ans_code), .cmd_vld_o(cmd_vld), .cmd_o(cmd)
    );

    // 100 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // hang guard, well above the expected run
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            test_done();
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] s);
        n_tests++;
        if (s !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    // f is {frame check ok, family match, id match}; model first, then card
    task automatic cmd_chk(input logic [2:0] c, input logic [2:0] f, input logic [3:0] fi);
        logic [2:0] a;
        logic [2:0] r;
        a = 3'h0;
        if (f[2] && c <= CTBC_CMD_WAKEUP && m_st != CTBC_ACTIVE && !(m_st == CTBC_HALTED && c == CTBC_CMD_REQUEST))
        begin
            a = f[1] ? CTBC_ANS_REQUEST : 3'h0;
            m_st = f[1] ? CTBC_ANSWERED : CTBC_IDLE;
        end
        else if (f[2] && f[0] && c == CTBC_CMD_HALT && m_st == CTBC_ANSWERED)
        begin
            a = CTBC_ANS_HALT;
            m_st = CTBC_HALTED;
        end
        else if (f[2] && f[0] && c == CTBC_CMD_ACTIVATE && m_st == CTBC_ANSWERED && fi <= CTBC_FSDI_MAX)
        begin
            a = CTBC_ANS_ACTIVATE;
            m_st = CTBC_ACTIVE;
            m_fsd = 9'(fsd_tbl[fi]);
        end
        else if (f[2] && c == CTBC_CMD_RELEASE && m_st == CTBC_ACTIVE)
        begin
            a = CTBC_ANS_RELEASE;
            m_st = CTBC_HALTED;
        end
        rdr.send({c, f, 3'h0, 5'h2, fi}, r);
        chk("answer", 9'(a), 9'(r));
        chk("state", 9'(m_st), 9'(state));
        chk("fsd", m_fsd, reader_frame_size);
    endtask

    // every selected code, descending: bad check, unmatched, good
    task automatic sweep(input logic [6:0] m);
        for (int c = 6; c >= 0; c--)
            for (int v = 0; v < 3; v++)
                if (m[c])
                    cmd_chk(3'(c), (v == 0) ? 3'h3 : ((v == 1) ? 3'h4 : 3'h7), 4'h0);
    endtask

    // information frame, response ready after dly cycles
    task automatic blk(input logic [8:0] len, input int dly);
        logic [2:0] r;
        int k;
        rdr.send({CTBC_CMD_IBLOCK, 3'h7, 12'h0}, r);
        chk("block early", 9'h0, 9'(r));
        rsp_len_i = len;
        repeat (dly) @(negedge clk_i);
        rsp_rdy_i = 1'b1;
        k = 0;
        while (ans_vld !== 1'b1 && k < 4)
        begin
            @(negedge clk_i);
            k++;
        end
        rsp_rdy_i = 1'b0;
        rsp_len_i = ~len;
        chk("block answer", 9'h1, {8'h0, ans_vld});
        chk("block code", 9'(CTBC_ANS_BLOCK), 9'(ans_code));
        chk("block len", (len < m_fsd) ? len : m_fsd, ans_len);
        chk("state", 9'(m_st), 9'(state));
    endtask

    // main sequence
    initial
    begin
        n_fail = 0;
        n_tests = 0;
        lfsr_q = 32'h7104;
        {nrst_i, en_i, rsp_rdy_i, rsp_len_i} = '0;
        m_st = CTBC_IDLE;
        m_fsd = CTBC_FSD_RESET;
        repeat (20) @(negedge clk_i);
        chk("reset state", 9'(m_st), 9'(state));
        chk("reset answer", 9'h0, {8'h0, ans_vld});
        chk("reset fsd", m_fsd, reader_frame_size);
        nrst_i = 1'b1;
        rdr.send({CTBC_CMD_REQUEST, 3'h7, 12'h0}, g);
        chk("frozen", 9'h0, 9'(g));
        en_i = 1'b1;
        sweep(7'h7d);
        cmd_chk(CTBC_CMD_ACTIVATE, 3'h6, 4'h0);
        cmd_chk(CTBC_CMD_ACTIVATE, 3'h3, 4'h0);
        for (int i = 0; i < 9; i++)
        begin
            lfsr_q = lfsr_next(lfsr_q);
            cmd_chk(CTBC_CMD_ACTIVATE, 3'h7, 4'(9 + lfsr_q[2:0] % 7));
            cmd_chk(CTBC_CMD_ACTIVATE, 3'h7, 4'(i));
            blk(lfsr_q[20:12], int'(lfsr_q[31:24]));
            cmd_chk(CTBC_CMD_RELEASE, 3'h7, 4'h0);
            cmd_chk(CTBC_CMD_WAKEUP, 3'h7, 4'h0);
        end
        cmd_chk(CTBC_CMD_ACTIVATE, 3'h7, 4'h8);
        sweep(7'h1f);
        // no response ready, so the waiting time runs out
        rdr.send({CTBC_CMD_IBLOCK, 3'h7, 12'h0}, g);
        n = 0;
        while (fwt_err !== 1'b1 && n < 600)
        begin
            @(negedge clk_i);
            n++;
        end
        chk("wait expiry", 9'h1, 9'(n > 474 && n < 490));
        blk(9'h1ff, 3);
        cmd_chk(CTBC_CMD_RELEASE, 3'h7, 4'h0);
        sweep(7'h7d);
        cmd_chk(CTBC_CMD_WAKEUP, 3'h3, 4'h0);
        cmd_chk(CTBC_CMD_WAKEUP, 3'h5, 4'h0);
        // slot counts 2, 4, 8 and 16
        for (int e = 1; e < 5; e++)
        begin
            seen = '0;
            for (int r = 0; r < 24; r++)
            begin
                rdr.round(3'(e), hits, slot);
                chk("slot hits", 9'h1, 9'(hits));
                chk("drawn state", 9'(CTBC_ANSWERED), 9'(state));
                seen[slot] = 1'b1;
                m_st = CTBC_ANSWERED;
                cmd_chk(CTBC_CMD_REQUEST, 3'h5, 4'h0);
                lfsr_q = lfsr_next(lfsr_q);
                rsp_len_i = lfsr_q[8:0];
                repeat (int'(lfsr_q[3:0])) @(negedge clk_i);
            end
            chk("slot spread", 9'h1, 9'($countones(seen) >= ((e >= 3) ? 6 : (1 << e))));
        end
        test_done();
    end
endmodule
`default_nettype wire
